// File: shared/bic_pkg.sv
// Shared constants and carrier types for the backplane slot controller.
// Assumes a single 250 MHz system clock and bus pins already buffered on-chip.

package bic_pkg;

	// ---------------------------------------------------------------
	// Widths and default settings
	// ---------------------------------------------------------------
	localparam int BIC_LINES = 16;                  // Shared address/data lines
	localparam int BIC_PAGE_W = 13;                 // Offset width inside the I/O page
	localparam logic [12:0] BIC_IO_OFFSET_DEF = 13'h1f40; // Default slot offset, arbitrary
	localparam logic [15:0] BIC_VECTOR_DEF = 16'h00c0;    // Default interrupt vector
	localparam logic [15:0] BIC_ZERO_WORD = 16'h0000;     // Cleared word value
	localparam int BIC_SYNC_STAGES = 2;             // Flip-flops ahead of any pin logic

	// ---------------------------------------------------------------
	// Reset values of pin-facing outputs (all negated)
	// ---------------------------------------------------------------
	localparam logic BIC_NEGATED = 1'b1;            // Active-low line at rest
	localparam logic BIC_OE_OFF = 1'b1;             // Output enable released

	// ---------------------------------------------------------------
	// Pin bundles
	// ---------------------------------------------------------------
	// Control lines arriving from the backplane, all active low
	typedef struct packed {
		logic sync_strobe_n;
		logic data_in_strobe_n;
		logic data_out_strobe_n;
		logic io_page_select_n;
		logic int_ack_in_n;
		logic dma_grant_in_n;
		logic system_init_n;
	} bic_pins_in_type;

	// Control lines driven toward the backplane, all active low
	typedef struct packed {
		logic irq_level4_n;
		logic int_ack_out_n;
		logic dma_request_n;
		logic dma_grant_out_n;
		logic dma_grant_ack_n;
		logic slave_reply_n;
	} bic_pins_out_type;

	// Reset image of the outgoing bundle
	localparam bic_pins_out_type BIC_PINS_OUT_RST = '{default: 1'b1};

endpackage : bic_pkg

// File: hdl/bic_slot_ctrl.sv
// Slot-side controller: interrupt request and acknowledge chain, DMA grant
// chain, one I/O page word and system initialize handling.
// Assumes backplane pins arrive asynchronous to clk_sys and that a user
// circuit on clk_sys supplies interrupt events, DMA wishes and read data.

`timescale 1ns/1ps

// What this block does
// - Assert level-4 request when enable and request set
// - Accept acknowledge only when requesting and highest
// - Otherwise forward acknowledge to next device
// - I/O page select decodes address lines 0..12
// - Requesting device acknowledges grant, ending propagation
// - Initialize clears registers and returns to state 0
// - Address first, then data, on shared lines
// - Assert reply with vector during interrupt acknowledge
// - Data strobe without sync means interrupt operation
module bic_slot_ctrl #(
	parameter logic [12:0] IO_OFFSET = bic_pkg::BIC_IO_OFFSET_DEF,
	parameter logic [15:0] VECTOR = bic_pkg::BIC_VECTOR_DEF
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Backplane control pins
	input wire bic_pkg::bic_pins_in_type bus_in,
	output bic_pkg::bic_pins_out_type bus_out,
	// Shared address/data lines, split into three signals
	input wire logic [15:0] lines_in,
	output logic [15:0] lines_out,
	output logic lines_oe_n,
	// User side: interrupt
	input wire logic int_enable,
	input wire logic int_raise,
	input wire logic higher_prio_pending,
	output logic int_serviced,
	// User side: DMA
	input wire logic dma_want,
	output logic dma_owner,
	// User side: I/O page word
	input wire logic [15:0] rd_data,
	output logic [15:0] wr_data,
	output logic wr_valid
);
	import bic_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	bic_pins_in_type pin_meta_reg;     // First stage, read only by second
	bic_pins_in_type pin_reg;          // Safe copy of the control pins
	logic [15:0] line_meta_reg;        // First stage of the shared lines
	logic [15:0] line_reg;             // Safe copy of the shared lines
	logic init_now;                    // System initialize asserted

	// Two flops per pin; the lines settle before their strobes so the
	// same latency keeps address and strobe in step
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_meta_reg <= '1;
			pin_reg <= '1;
			line_meta_reg <= BIC_ZERO_WORD;
			line_reg <= BIC_ZERO_WORD;
		end else begin
			pin_meta_reg <= bus_in;
			pin_reg <= pin_meta_reg;
			line_meta_reg <= lines_in;
			line_reg <= line_meta_reg;
		end
	end

	assign init_now = !pin_reg.system_init_n;

	// ---------------------------------------------------------------
	// Interrupt request flip-flops
	// ---------------------------------------------------------------
	logic int_en_reg;                  // Interrupt enable flip-flop
	logic int_req_reg;                 // Interrupt request flip-flop
	logic int_active;                  // Both set: requesting on the bus
	logic intack_take;                 // Acknowledge accepted this cycle
	logic irq_n_reg;                   // Level-4 request pin

	assign int_active = int_en_reg && int_req_reg;

	// Request set wins over the clear from an accepted acknowledge
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			int_en_reg <= 1'b0;
			int_req_reg <= 1'b0;
		end else if (init_now) begin
			int_en_reg <= 1'b0;
			int_req_reg <= 1'b0;
		end else begin
			int_en_reg <= int_enable;
			if (int_raise)
				int_req_reg <= 1'b1;
			else if (intack_take)
				int_req_reg <= 1'b0;
		end
	end

	// Request pin follows the two flip-flops
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			irq_n_reg <= BIC_NEGATED;
		else
			irq_n_reg <= !int_active;
	end

	// ---------------------------------------------------------------
	// Bus cycle state machine
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		XF_IDLE, XF_ADDR, XF_READ, XF_WRITE, XF_INTACK_TAKE, XF_INTACK_PASS
	} bic_xf_type;

	bic_xf_type xf_reg;
	bic_xf_type xf_next;
	logic sel_reg;                     // This slot addressed in current cycle
	logic intack_op;                   // Data strobe without sync

	// A data strobe seen without sync is an interrupt cycle
	assign intack_op = !pin_reg.data_in_strobe_n && pin_reg.sync_strobe_n;
	assign intack_take = (xf_reg == XF_IDLE) && intack_op && !pin_reg.int_ack_in_n
		&& int_active && !higher_prio_pending;

	// Next state
	always_comb begin
		xf_next = xf_reg;
		unique case (xf_reg)
			XF_IDLE: begin
				if (!pin_reg.sync_strobe_n)
					xf_next = XF_ADDR;
				else if (intack_op && !pin_reg.int_ack_in_n)
					xf_next = intack_take ? XF_INTACK_TAKE : XF_INTACK_PASS;
			end
			XF_ADDR: begin
				if (pin_reg.sync_strobe_n)
					xf_next = XF_IDLE;
				else if (sel_reg && !pin_reg.data_in_strobe_n)
					xf_next = XF_READ;
				else if (sel_reg && !pin_reg.data_out_strobe_n)
					xf_next = XF_WRITE;
			end
			XF_READ: begin
				if (pin_reg.data_in_strobe_n)
					xf_next = XF_ADDR;
			end
			XF_WRITE: begin
				if (pin_reg.data_out_strobe_n)
					xf_next = XF_ADDR;
			end
			XF_INTACK_TAKE: begin
				if (pin_reg.data_in_strobe_n)
					xf_next = XF_IDLE;
			end
			XF_INTACK_PASS: begin
				// Hold the forwarded acknowledge until the data strobe or the incoming acknowledge negates
				if (pin_reg.data_in_strobe_n || pin_reg.int_ack_in_n)
					xf_next = XF_IDLE;
			end
		endcase
	end

	// State register; initialize returns it to the idle state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			xf_reg <= XF_IDLE;
		else if (init_now)
			xf_reg <= XF_IDLE;
		else
			xf_reg <= xf_next;
	end

	// Address decode at the start of each cycle: only the low 13 lines
	// count while the page select is asserted
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			sel_reg <= 1'b0;
		else if (init_now)
			sel_reg <= 1'b0;
		else if (xf_reg == XF_IDLE && !pin_reg.sync_strobe_n)
			sel_reg <= !pin_reg.io_page_select_n
				&& (line_reg[BIC_PAGE_W-1:0] == IO_OFFSET);
	end

	// ---------------------------------------------------------------
	// Reply, acknowledge forward and line drivers
	// ---------------------------------------------------------------
	logic reply_n_reg;
	logic ack_out_n_reg;
	logic [15:0] lines_out_reg;
	logic oe_n_reg;

	// Outputs follow the next state so they align with the state register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reply_n_reg <= BIC_NEGATED;
			ack_out_n_reg <= BIC_NEGATED;
			lines_out_reg <= BIC_ZERO_WORD;
			oe_n_reg <= BIC_OE_OFF;
		end else if (init_now) begin
			reply_n_reg <= BIC_NEGATED;
			ack_out_n_reg <= BIC_NEGATED;
			lines_out_reg <= BIC_ZERO_WORD;
			oe_n_reg <= BIC_OE_OFF;
		end else begin
			reply_n_reg <= !(xf_next inside {XF_READ, XF_WRITE, XF_INTACK_TAKE});
			ack_out_n_reg <= (xf_next != XF_INTACK_PASS);
			oe_n_reg <= !(xf_next inside {XF_READ, XF_INTACK_TAKE});
			if (xf_next == XF_INTACK_TAKE)
				lines_out_reg <= VECTOR;
			else if (xf_next == XF_READ)
				lines_out_reg <= rd_data;
			else
				lines_out_reg <= BIC_ZERO_WORD;
		end
	end

	// Write capture and service pulse
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_data <= BIC_ZERO_WORD;
			wr_valid <= 1'b0;
			int_serviced <= 1'b0;
		end else if (init_now) begin
			wr_data <= BIC_ZERO_WORD;
			wr_valid <= 1'b0;
			int_serviced <= 1'b0;
		end else begin
			wr_valid <= (xf_reg == XF_ADDR) && (xf_next == XF_WRITE);
			if ((xf_reg == XF_ADDR) && (xf_next == XF_WRITE))
				wr_data <= line_reg;
			int_serviced <= intack_take;
		end
	end

	// ---------------------------------------------------------------
	// DMA grant chain
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {DM_IDLE, DM_REQ, DM_OWN, DM_PASS} bic_dm_type;

	bic_dm_type dm_reg;
	bic_dm_type dm_next;
	logic dma_req_n_reg;
	logic grant_out_n_reg;
	logic grant_ack_n_reg;

	// A grant seen before this slot asked is passed on, never taken
	always_comb begin
		dm_next = dm_reg;
		unique case (dm_reg)
			DM_IDLE: begin
				if (!pin_reg.dma_grant_in_n)
					dm_next = DM_PASS;
				else if (dma_want)
					dm_next = DM_REQ;
			end
			DM_REQ: begin
				if (!pin_reg.dma_grant_in_n)
					dm_next = DM_OWN;
				else if (!dma_want)
					dm_next = DM_IDLE;
			end
			DM_OWN: begin
				if (!dma_want)
					dm_next = DM_IDLE;
			end
			DM_PASS: begin
				if (pin_reg.dma_grant_in_n)
					dm_next = DM_IDLE;
			end
		endcase
	end

	// Refresh protection is the master's duty; the user drops dma_want
	// between transfers to leave room for it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dm_reg <= DM_IDLE;
			dma_req_n_reg <= BIC_NEGATED;
			grant_out_n_reg <= BIC_NEGATED;
			grant_ack_n_reg <= BIC_NEGATED;
		end else if (init_now) begin
			dm_reg <= DM_IDLE;
			dma_req_n_reg <= BIC_NEGATED;
			grant_out_n_reg <= BIC_NEGATED;
			grant_ack_n_reg <= BIC_NEGATED;
		end else begin
			dm_reg <= dm_next;
			dma_req_n_reg <= (dm_next != DM_REQ);
			grant_out_n_reg <= (dm_next != DM_PASS);
			grant_ack_n_reg <= (dm_next != DM_OWN);
		end
	end

	// ---------------------------------------------------------------
	// Output assembly
	// ---------------------------------------------------------------
	assign bus_out.irq_level4_n = irq_n_reg;
	assign bus_out.int_ack_out_n = ack_out_n_reg;
	assign bus_out.dma_request_n = dma_req_n_reg;
	assign bus_out.dma_grant_out_n = grant_out_n_reg;
	assign bus_out.dma_grant_ack_n = grant_ack_n_reg;
	assign bus_out.slave_reply_n = reply_n_reg;
	assign lines_out = lines_out_reg;
	assign lines_oe_n = oe_n_reg;
	assign dma_owner = !grant_ack_n_reg;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_irq_follows_ff: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1 |=> bus_out.irq_level4_n == !$past(int_active))
		else $error("level-4 request not asserted");
	a_intack_take_vec: assert property (@(posedge clk_sys) disable iff (rst)
		intack_take && !init_now |=> !bus_out.slave_reply_n && lines_out == VECTOR && !lines_oe_n)
		else $error("accepted acknowledge did not present vector");
	a_intack_forward: assert property (@(posedge clk_sys) disable iff (rst)
		xf_reg == XF_IDLE && intack_op && !pin_reg.int_ack_in_n && !intack_take && !init_now
		|=> !bus_out.int_ack_out_n)
		else $error("acknowledge not forwarded");
	a_intack_blocks: assert property (@(posedge clk_sys) disable iff (rst)
		xf_reg == XF_INTACK_TAKE |-> bus_out.int_ack_out_n && !bus_out.slave_reply_n)
		else $error("accepting slot leaked acknowledge");
	a_page_decode: assert property (@(posedge clk_sys) disable iff (rst)
		xf_reg == XF_READ |-> sel_reg)
		else $error("read answered without page match");
	a_grant_pass: assert property (@(posedge clk_sys) disable iff (rst)
		dm_reg == DM_IDLE && !pin_reg.dma_grant_in_n && !init_now
		|=> !bus_out.dma_grant_out_n && bus_out.dma_grant_ack_n)
		else $error("unrequested grant not passed");
	a_grant_take: assert property (@(posedge clk_sys) disable iff (rst)
		dm_reg == DM_REQ && !pin_reg.dma_grant_in_n && !init_now
		|=> !bus_out.dma_grant_ack_n && bus_out.dma_grant_out_n && bus_out.dma_request_n)
		else $error("requested grant not acknowledged");
	a_init_clears: assert property (@(posedge clk_sys) disable iff (rst)
		init_now |=> xf_reg == XF_IDLE && dm_reg == DM_IDLE && !int_req_reg
		&& bus_out.slave_reply_n)
		else $error("initialize left state behind");
	a_read_data: assert property (@(posedge clk_sys) disable iff (rst)
		xf_reg == XF_ADDR && xf_next == XF_READ && !init_now
		|=> lines_out == $past(rd_data) && !bus_out.slave_reply_n)
		else $error("read data not driven");
	a_intack_nosync: assert property (@(posedge clk_sys) disable iff (rst)
		xf_reg == XF_IDLE && intack_op && !init_now
		|=> !(xf_reg inside {XF_ADDR, XF_READ, XF_WRITE}) && !wr_valid)
		else $error("strobe without sync started a data transfer");

endmodule : bic_slot_ctrl

// File: testbench/bic_bus_model.sv
// Far side of the slot: processor, arbiter and chain neighbours.
// Assumes the bench calls its tasks and that all pins are active low.
`timescale 1ns/1ps
module bic_bus_model (
	// Clock
	input wire logic clk_sys,
	// Toward the slot
	output bic_pkg::bic_pins_in_type bus_in,
	output logic [15:0] lines_in,
	// From the slot
	input wire bic_pkg::bic_pins_out_type bus_out,
	input wire logic [15:0] lines_out,
	input wire logic lines_oe_n
);
	import bic_pkg::*;
	// ------------------------------------------------------------
	// Shared lines
	// ------------------------------------------------------------
	logic [15:0] mst_val; // Master's word
	logic mst_oe; // Master drives the lines
	logic [15:0] last_val; // Last level, for released lines
	int slow; // Extra address hold, for a slow master
	// Released lines toggle, so a stale word never looks valid
	assign lines_in = mst_oe ? mst_val : (!lines_oe_n ? lines_out : ~last_val);
	always @(posedge clk_sys) last_val <= lines_in;
	initial begin
		bus_in = '1;
		mst_oe = 1'b0;
		mst_val = 16'h0000;
		last_val = 16'h0000;
		slow = 0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	// Waits for the reply level, taking the word at that edge
	task automatic await(input logic lvl, output logic seen, output logic [15:0] rd);
		seen = 1'b0;
		for (int i = 0; i < 10 && !seen; i++) begin
			@(posedge clk_sys);
			rd = lines_in;
			seen = (bus_out.slave_reply_n === lvl);
		end
		#1;
	endtask : await
	// ------------------------------------------------------------
	// Bus cycle: address with sync, then one strobe
	// ------------------------------------------------------------
	task automatic cycle(input logic [15:0] addr, input logic sel, input logic wr,
		input logic [15:0] wd, output logic [15:0] rd, output logic ok);
		logic dummy;
		logic [15:0] junk;
		mst_val = addr;
		mst_oe = 1'b1;
		bus_in.io_page_select_n = !sel;
		bus_in.sync_strobe_n = 1'b0;
		step(3 + slow);
		mst_oe = wr;
		mst_val = wd;
		if (wr) begin
			bus_in.data_out_strobe_n = 1'b0;
		end else begin
			bus_in.data_in_strobe_n = 1'b0;
		end
		await(1'b0, ok, rd);
		bus_in.data_in_strobe_n = 1'b1;
		bus_in.data_out_strobe_n = 1'b1;
		await(1'b1, dummy, junk);
		bus_in.sync_strobe_n = 1'b1;
		bus_in.io_page_select_n = 1'b1;
		mst_oe = 1'b0;
		step(3);
	endtask : cycle
	// Interrupt acknowledge: data strobe without sync, ack into the chain
	task automatic int_ack(output logic [15:0] vec, output logic acc, output logic pas);
		acc = 1'b0;
		pas = 1'b0;
		bus_in.data_in_strobe_n = 1'b0;
		bus_in.int_ack_in_n = 1'b0;
		for (int i = 0; i < 10 && !acc && !pas; i++) begin
			@(posedge clk_sys);
			vec = lines_in;
			acc = (bus_out.slave_reply_n === 1'b0);
			pas = (bus_out.int_ack_out_n === 1'b0);
		end
		#1;
		bus_in.data_in_strobe_n = 1'b1;
		bus_in.int_ack_in_n = 1'b1;
		step(6);
	endtask : int_ack
	// Arbiter grant into the chain
	task automatic grant(output logic acc, output logic pas);
		acc = 1'b0;
		pas = 1'b0;
		bus_in.dma_grant_in_n = 1'b0;
		for (int i = 0; i < 10 && !acc && !pas; i++) begin
			@(posedge clk_sys);
			acc = (bus_out.dma_grant_ack_n === 1'b0);
			pas = (bus_out.dma_grant_out_n === 1'b0);
		end
		#1;
		bus_in.dma_grant_in_n = 1'b1;
		step(5);
	endtask : grant
	// System initialize pulse
	task automatic init_pulse();
		bus_in.system_init_n = 1'b0;
		step(4);
		bus_in.system_init_n = 1'b1;
		step(4);
	endtask : init_pulse
endmodule : bic_bus_model

// File: testbench/bic_slot_ctrl_tb.sv
// Self-checking bench for the slot controller.
// Assumes the bus model file and the package are compiled first.
`timescale 1ns/1ps
module bic_slot_ctrl_tb;
	import bic_pkg::*;
	logic clk_sys, rst;
	bic_pins_in_type bus_in;
	bic_pins_out_type bus_out;
	logic [15:0] lines_in, lines_out, rd_data, wr_data, wr_seen, rd, vec;
	logic lines_oe_n, int_enable, int_raise, higher_prio_pending, int_serviced;
	logic dma_want, dma_owner, wr_valid, ok, acc, pas;
	int mismatches, tests_run, cycles, serv_cnt, wr_cnt;
	bic_slot_ctrl bic_slot_ctrl_i (.clk_sys(clk_sys), .rst(rst), .bus_in(bus_in),
		.bus_out(bus_out), .lines_in(lines_in), .lines_out(lines_out),
		.lines_oe_n(lines_oe_n), .int_enable(int_enable), .int_raise(int_raise),
		.higher_prio_pending(higher_prio_pending), .int_serviced(int_serviced),
		.dma_want(dma_want), .dma_owner(dma_owner), .rd_data(rd_data),
		.wr_data(wr_data), .wr_valid(wr_valid));
	bic_bus_model bic_bus_model_i (.clk_sys(clk_sys), .bus_in(bus_in),
		.lines_in(lines_in), .bus_out(bus_out), .lines_out(lines_out),
		.lines_oe_n(lines_oe_n));
	// ------------------------------------------------------------
	// Clock, pulse counters and hang guard
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (int_serviced === 1'b1) serv_cnt++;
		if (wr_valid === 1'b1) begin
			wr_cnt++;
			wr_seen <= wr_data;
		end
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic raise_irq();
		int_raise = 1'b1;
		step(1);
		int_raise = 1'b0;
		step(3);
	endtask : raise_irq
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check(bus_out, BIC_PINS_OUT_RST);
		check(lines_oe_n, 1'b1);
		check(dma_owner, 1'b0);
	endtask : t_reset
	// Only offset bits 12..0 decide; upper bits are ignored
	task automatic t_io();
		rd_data = 16'ha5c3;
		bic_bus_model_i.cycle({3'b101, BIC_IO_OFFSET_DEF}, 1'b1, 1'b0, 16'h0, rd, ok);
		check(ok, 1'b1);
		check(rd, 16'ha5c3);
		bic_bus_model_i.cycle({3'b000, BIC_IO_OFFSET_DEF}, 1'b0, 1'b0, 16'h0, rd, ok);
		check(ok, 1'b0);
		bic_bus_model_i.cycle({3'b000, BIC_IO_OFFSET_DEF ^ 13'h1000}, 1'b1, 1'b0,
			16'h0, rd, ok);
		check(ok, 1'b0);
		bic_bus_model_i.slow = 4;
		bic_bus_model_i.cycle({3'b000, BIC_IO_OFFSET_DEF}, 1'b1, 1'b1, 16'h3c5a, rd, ok);
		bic_bus_model_i.slow = 0;
		check(ok, 1'b1);
		check(wr_cnt, 1);
		check(wr_seen, 16'h3c5a);
	endtask : t_io
	task automatic t_irq();
		int_enable = 1'b1;
		raise_irq();
		check(bus_out.irq_level4_n, 1'b0);
		higher_prio_pending = 1'b1;
		bic_bus_model_i.int_ack(vec, acc, pas);
		check({acc, pas}, 2'b01);
		higher_prio_pending = 1'b0;
		bic_bus_model_i.int_ack(vec, acc, pas);
		check({acc, pas}, 2'b10);
		check(vec, BIC_VECTOR_DEF);
		check(serv_cnt, 1);
		check(bus_out.irq_level4_n, 1'b1);
		bic_bus_model_i.int_ack(vec, acc, pas);
		check({acc, pas}, 2'b01);
		int_enable = 1'b0;
		raise_irq();
		check(bus_out.irq_level4_n, 1'b1);
		int_enable = 1'b1;
		step(2);
		check(bus_out.irq_level4_n, 1'b0);
		bic_bus_model_i.init_pulse();
		check(bus_out.irq_level4_n, 1'b1);
	endtask : t_irq
	task automatic t_dma();
		bic_bus_model_i.grant(acc, pas);
		check({acc, pas}, 2'b01);
		dma_want = 1'b1;
		step(2);
		check(bus_out.dma_request_n, 1'b0);
		bic_bus_model_i.grant(acc, pas);
		check({acc, pas}, 2'b10);
		check(dma_owner, 1'b1);
		dma_want = 1'b0;
		step(3);
		check({dma_owner, bus_out.dma_grant_ack_n}, 2'b01);
	endtask : t_dma
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		mismatches = 0;
		tests_run = 0;
		cycles = 0;
		serv_cnt = 0;
		wr_cnt = 0;
		rst = 1'b1;
		int_enable = 1'b0;
		int_raise = 1'b0;
		higher_prio_pending = 1'b0;
		dma_want = 1'b0;
		rd_data = 16'h0000;
		step(10);
		rst = 1'b0;
		step(1);
		t_reset();
		t_io();
		t_irq();
		t_dma();
		report_and_stop();
	end
endmodule : bic_slot_ctrl_tb
